/* rtl/config_fuse_cfg.svh */
// offsets, field positions, reset values and counts of the fuse bank
`ifndef CONFIG_FUSE_CFG_SVH
`define CONFIG_FUSE_CFG_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define CFB_IDX_BOR    22'h300002
`define CFB_IDX_WDT    22'h300003
`define CFB_IDX_ROUTE  22'h300005
`define CFB_IDX_DPS    22'h300006
`define CFB_IDX_CP     22'h300008
`define CFB_IDX_WCTL   22'h300010
`define CFB_IDX_WSTAT  22'h300011
`define CFB_IDX_ERASE  22'h300012

// ----------------------------------------------------------------
// implemented bits and unprogrammed value
// ----------------------------------------------------------------
`define CFB_MASK_BOR   8'h0f
`define CFB_MASK_WDT   8'h0f
`define CFB_MASK_ROUTE 8'h01
`define CFB_MASK_DPS   8'h85
`define CFB_MASK_CP    8'h0f
`define CFB_ERASED     8'hff

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFB_WDT_EN_BIT 0
`define CFB_WDT_PS_LSB 1
`define CFB_ROUTE_BIT  0
`define CFB_LOWV_BIT   2
`define CFB_STVR_BIT   0
`define CFB_WCTL_SOFT  0
`define CFB_WCTL_KICK  1
`define CFB_ST_RUN     0
`define CFB_ST_TO      1
`define CFB_ST_STK     2
`define CFB_ERASE_BIT  0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CFB_WDT_BASE_CYCLES 16'd1000

`endif

/* rtl/config_fuse_pkg.sv */
// types shared by the configuration fuse bank
package config_fuse_pkg;

	typedef enum logic [1:0] {
		WD_OFF = 2'b01,
		WD_RUN = 2'b10
	} wd_state_t;

	typedef struct packed {
		logic       full;
		logic       under;
	} stack_evt_t;

	typedef struct packed {
		logic       out;
		logic       oe;
	} pin_drive_t;

endpackage

/* rtl/config_fuse_bank.sv */
// configuration fuse bank with apb access, watchdog and pin routing
//
// How it works
// R1: bits 3..1 of the watchdog byte pick a postscale of 1:1 up to 1:128.
// R2: fuse enable bit 0 forces the watchdog on, else the soft enable rules.
// R3: route bit 0 sends unit 2 to port c pin 1 when 1, port b pin 3 when 0.
// R4: bit 2 of the debug byte allows low voltage programming entry.
// R5: bit 0 of the debug byte lets stack full or underflow reset the part.
// R6: every unimplemented bit of the bank reads as zero.
// R7: code protect bit 1 low blocks external reads of 002000-003fff.
// R8: code protect bit 2 low blocks external reads of 004000-005fff.
// R9: code protect bit 3 low blocks external reads of 006000-007fff.
// R10: the programmer keeps block 2 and 3 bits at 1 on small variants.
// R11: all implemented bits read 1 when unprogrammed; protect bits only ever clear until an erase write sets them back to 1.
// R12: watchdog time-out is the base period times the postscale ratio.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "config_fuse_cfg.svh"

module config_fuse_bank #(
	parameter logic [15:0] WDT_BASE_CYCLES = `CFB_WDT_BASE_CYCLES
) (
	// clock and reset
	input  wire logic                       CLK,
	input  wire logic                       ARST_N,
	// apb slave
	input  wire logic                       PSEL,
	input  wire logic                       PENABLE,
	input  wire logic                       PWRITE,
	input  wire logic [23:0]                PADDR,
	input  wire logic [31:0]                PWDATA,
	input  wire logic [3:0]                 PSTRB,
	output logic                            PREADY,
	output logic      [31:0]                PRDATA,
	output logic                            PSLVERR,
	// watchdog and stack
	input  wire config_fuse_pkg::stack_evt_t STACK_EVT,
	output logic                            WDT_TIMEOUT,
	output logic                            STACK_RESET,
	// unit 2 pin routing
	input  wire config_fuse_pkg::pin_drive_t UNIT2_DRV,
	output logic                            UNIT2_IN,
	input  wire logic                       PC1_IN,
	input  wire logic                       PB3_IN,
	output config_fuse_pkg::pin_drive_t     PC1_DRV,
	output config_fuse_pkg::pin_drive_t     PB3_DRV,
	// low voltage programming entry
	input  wire logic                       LOW_VOLT_REQ,
	output logic                            LOW_VOLT_OK,
	// external read of program memory
	input  wire logic [20:0]                EXT_RD_ADDR,
	output logic                            EXT_RD_BLOCKED
);

	// ----------------------------------------------------------------
	// fuse bytes
	// ----------------------------------------------------------------
	logic [7:0]  bor_r;
	logic [7:0]  wdt_r;
	logic [7:0]  route_r;
	logic [7:0]  dps_r;
	logic [7:0]  cp_r;
	logic        soft_en_r;
	logic        to_flag_r;
	logic        stk_flag_r;
	logic [31:0] rdata_nxt;
	logic        hit_bor;
	logic        hit_wdt;
	logic        hit_route;
	logic        hit_dps;
	logic        hit_cp;
	logic        hit_wctl;
	logic        hit_wstat;
	logic        hit_erase;
	logic        mapped;
	logic        setup;
	logic        wr_acc;
	logic        lane0;
	logic        erase_wr;
	logic        kick;

	assign setup     = PSEL && !PENABLE;
	assign wr_acc    = PSEL && PENABLE && PWRITE && mapped;
	assign lane0     = PSTRB[0];
	assign hit_bor   = PADDR == {`CFB_IDX_BOR, 2'b00};
	assign hit_wdt   = PADDR == {`CFB_IDX_WDT, 2'b00};
	assign hit_route = PADDR == {`CFB_IDX_ROUTE, 2'b00};
	assign hit_dps   = PADDR == {`CFB_IDX_DPS, 2'b00};
	assign hit_cp    = PADDR == {`CFB_IDX_CP, 2'b00};
	assign hit_wctl  = PADDR == {`CFB_IDX_WCTL, 2'b00};
	assign hit_wstat = PADDR == {`CFB_IDX_WSTAT, 2'b00};
	assign hit_erase = PADDR == {`CFB_IDX_ERASE, 2'b00};
	assign mapped    = hit_bor | hit_wdt | hit_route | hit_dps | hit_cp |
	                   hit_wctl | hit_wstat | hit_erase;
	assign erase_wr  = wr_acc && lane0 && hit_erase &&
	                   PWDATA[`CFB_ERASE_BIT];
	assign kick      = wr_acc && lane0 && hit_wctl &&
	                   PWDATA[`CFB_WCTL_KICK];

	// zero wait states: data is staged in the setup cycle
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;

	// ----------------------------------------------------------------
	// fuse programming
	// ----------------------------------------------------------------
	// option fuses follow the written value; erase restores all implemented bits to ones
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			bor_r   <= `CFB_ERASED & `CFB_MASK_BOR; // see R11
			wdt_r   <= `CFB_ERASED & `CFB_MASK_WDT;
			route_r <= `CFB_ERASED & `CFB_MASK_ROUTE;
			dps_r   <= `CFB_ERASED & `CFB_MASK_DPS;
		end else if (erase_wr) begin
			bor_r   <= `CFB_ERASED & `CFB_MASK_BOR; // see R11
			wdt_r   <= `CFB_ERASED & `CFB_MASK_WDT;
			route_r <= `CFB_ERASED & `CFB_MASK_ROUTE;
			dps_r   <= `CFB_ERASED & `CFB_MASK_DPS;
		end else if (wr_acc && lane0) begin
			if (hit_bor)
				bor_r <= PWDATA[7:0] & `CFB_MASK_BOR; // see R6
			if (hit_wdt)
				wdt_r <= PWDATA[7:0] & `CFB_MASK_WDT; // see R6
			if (hit_route)
				route_r <= PWDATA[7:0] & `CFB_MASK_ROUTE; // see R6
			if (hit_dps)
				dps_r <= PWDATA[7:0] & `CFB_MASK_DPS; // see R6
		end
	end

	// protection may only tighten; only an erase write or reset can lift it
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			cp_r <= `CFB_ERASED & `CFB_MASK_CP; // see R11
		else if (erase_wr)
			cp_r <= `CFB_ERASED & `CFB_MASK_CP; // see R11
		else if (wr_acc && lane0 && hit_cp)
			cp_r <= cp_r & PWDATA[7:0]; // see R11
	end

	// ----------------------------------------------------------------
	// watchdog control and status
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			soft_en_r <= 1'b0;
		else if (wr_acc && lane0 && hit_wctl)
			soft_en_r <= PWDATA[`CFB_WCTL_SOFT];
	end

	// sticky flags: a new event wins over a write-one clear
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			to_flag_r  <= 1'b0;
			stk_flag_r <= 1'b0;
		end else begin
			if (WDT_TIMEOUT)
				to_flag_r <= 1'b1;
			else if (wr_acc && lane0 && hit_wstat && PWDATA[`CFB_ST_TO])
				to_flag_r <= 1'b0;
			if (STACK_RESET)
				stk_flag_r <= 1'b1;
			else if (wr_acc && lane0 && hit_wstat && PWDATA[`CFB_ST_STK])
				stk_flag_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// watchdog counter
	// ----------------------------------------------------------------
	config_fuse_pkg::wd_state_t wd_state;
	logic [15:0] pre_cnt_r;
	logic [6:0]  post_cnt_r;
	logic [2:0]  ps_sel;
	logic [6:0]  ratio_m1;
	logic        wd_tick;
	logic        fuse_en;
	logic        wd_run;

	assign ps_sel   = wdt_r[`CFB_WDT_PS_LSB +: 3];
	assign ratio_m1 = 7'((8'h01 << ps_sel) - 8'h01); // see R1
	assign fuse_en  = wdt_r[`CFB_WDT_EN_BIT];
	assign wd_run   = fuse_en || soft_en_r; // see R2
	assign wd_state = wd_run ? config_fuse_pkg::WD_RUN
	                         : config_fuse_pkg::WD_OFF;
	assign wd_tick  = pre_cnt_r == WDT_BASE_CYCLES - 16'h0001;
	assign WDT_TIMEOUT = wd_state == config_fuse_pkg::WD_RUN &&
	                     wd_tick && post_cnt_r == ratio_m1; // see R12

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pre_cnt_r  <= 16'h0000;
			post_cnt_r <= 7'h00;
		end else begin
			case (wd_state)
				config_fuse_pkg::WD_RUN: begin
					if (kick || WDT_TIMEOUT) begin
						pre_cnt_r  <= 16'h0000;
						post_cnt_r <= 7'h00;
					end else if (wd_tick) begin
						pre_cnt_r  <= 16'h0000;
						post_cnt_r <= post_cnt_r + 7'h01; // see R1
					end else begin
						pre_cnt_r <= pre_cnt_r + 16'h0001;
					end
				end
				default: begin
					pre_cnt_r  <= 16'h0000;
					post_cnt_r <= 7'h00;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// stack reset, pin routing, low voltage entry, protection
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			STACK_RESET <= 1'b0;
		else
			STACK_RESET <= (STACK_EVT.full || STACK_EVT.under) &&
			               dps_r[`CFB_STVR_BIT]; // see R5
	end

	// pins come from outside, so each passes two flops first
	logic [1:0] pc1_sync_r;
	logic [1:0] pb3_sync_r;
	logic [1:0] lowv_sync_r;
	logic       route_c1;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pc1_sync_r <= 2'b00;
			pb3_sync_r <= 2'b00;
			lowv_sync_r <= 2'b00;
		end else begin
			pc1_sync_r <= {pc1_sync_r[0], PC1_IN};
			pb3_sync_r <= {pb3_sync_r[0], PB3_IN};
			lowv_sync_r <= {lowv_sync_r[0], LOW_VOLT_REQ};
		end
	end

	assign route_c1 = route_r[`CFB_ROUTE_BIT];

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			UNIT2_IN    <= 1'b0;
			LOW_VOLT_OK <= 1'b0;
		end else begin
			UNIT2_IN    <= route_c1 ? pc1_sync_r[1]
			                        : pb3_sync_r[1]; // see R3
			LOW_VOLT_OK <= lowv_sync_r[1] &&
			               dps_r[`CFB_LOWV_BIT]; // see R4
		end
	end

	// the unused pin is released, never driven low
	always_comb begin
		PC1_DRV = '0;
		PB3_DRV = '0;
		if (route_c1)
			PC1_DRV = UNIT2_DRV; // see R3
		else
			PB3_DRV = UNIT2_DRV; // see R3
	end

	// block 0 starts above the boot block; above 007fff is open
	logic in_low;
	logic blk_hit;

	assign in_low  = EXT_RD_ADDR[20:15] == 6'h00;
	assign blk_hit = in_low && !cp_r[EXT_RD_ADDR[14:13]] &&
	                 (EXT_RD_ADDR[14:13] != 2'b00 ||
	                  EXT_RD_ADDR[12:9] != 4'h0); // see R7 R8 R9

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			EXT_RD_BLOCKED <= 1'b0;
		else
			EXT_RD_BLOCKED <= blk_hit; // see R7 R8 R9
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_comb begin
		rdata_nxt = 32'h0000_0000; // see R6
		if (hit_bor)
			rdata_nxt[7:0] = bor_r;
		if (hit_wdt)
			rdata_nxt[7:0] = wdt_r;
		if (hit_route)
			rdata_nxt[7:0] = route_r;
		if (hit_dps)
			rdata_nxt[7:0] = dps_r;
		if (hit_cp)
			rdata_nxt[7:0] = cp_r;
		if (hit_wctl)
			rdata_nxt[`CFB_WCTL_SOFT] = soft_en_r;
		if (hit_wstat) begin
			rdata_nxt[`CFB_ST_RUN] = wd_run;
			rdata_nxt[`CFB_ST_TO]  = to_flag_r;
			rdata_nxt[`CFB_ST_STK] = stk_flag_r;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			PRDATA <= 32'h0000_0000;
		else if (setup && !PWRITE)
			PRDATA <= rdata_nxt;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [22:0] wd_age_r;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			wd_age_r <= 23'h000000;
		else if (wd_run && !kick && !WDT_TIMEOUT)
			wd_age_r <= wd_age_r + 23'h000001;
		else
			wd_age_r <= 23'h000000;
	end

	a_wdt_ratio_cnt: assert property (@(posedge CLK) disable iff (!ARST_N) // see R1 R12
		WDT_TIMEOUT |->
		wd_age_r + 23'h000001 == ({7'h00, WDT_BASE_CYCLES} << ps_sel))
		else $error("watchdog fired at wrong postscale count");
	a_wdt_fuse_on: assert property (@(posedge CLK) disable iff (!ARST_N) // see R2
		fuse_en && !wd_tick && !kick |=> pre_cnt_r == $past(pre_cnt_r) + 16'h0001)
		else $error("watchdog stopped while fuse enable set");
	a_wdt_off_quiet: assert property (@(posedge CLK) disable iff (!ARST_N) // see R2
		!wd_run |=> !WDT_TIMEOUT && pre_cnt_r == 16'h0000)
		else $error("disabled watchdog kept counting");
	a_route_sel: assert property (@(posedge CLK) disable iff (!ARST_N) // see R3
		route_c1 |-> PC1_DRV == UNIT2_DRV && PB3_DRV == '0)
		else $error("unit 2 routed to wrong pin");
	a_low_volt_gate: assert property (@(posedge CLK) disable iff (!ARST_N) // see R4
		LOW_VOLT_OK |-> $past(dps_r[`CFB_LOWV_BIT]) && $past(lowv_sync_r[1]))
		else $error("low voltage entry allowed while disabled");
	a_stack_reset: assert property (@(posedge CLK) disable iff (!ARST_N) // see R5
		(STACK_EVT.full || STACK_EVT.under) |=>
		STACK_RESET == $past(dps_r[`CFB_STVR_BIT]))
		else $error("stack reset does not follow its enable");
	a_unimpl_zero: assert property (@(posedge CLK) disable iff (!ARST_N) // see R6
		setup && !PWRITE && hit_wdt |=> PRDATA[31:4] == 28'h0000000)
		else $error("unimplemented watchdog bits read nonzero");
	a_blk1_protect: assert property (@(posedge CLK) disable iff (!ARST_N) // see R7
		EXT_RD_ADDR >= 21'h002000 && EXT_RD_ADDR <= 21'h003fff &&
		!cp_r[1] |=> EXT_RD_BLOCKED)
		else $error("block 1 read not blocked");
	a_blk2_protect: assert property (@(posedge CLK) disable iff (!ARST_N) // see R8
		EXT_RD_ADDR >= 21'h004000 && EXT_RD_ADDR <= 21'h005fff |=>
		EXT_RD_BLOCKED == !$past(cp_r[2]))
		else $error("block 2 protection wrong");
	a_blk3_protect: assert property (@(posedge CLK) disable iff (!ARST_N) // see R9
		EXT_RD_ADDR >= 21'h006000 && EXT_RD_ADDR <= 21'h007fff |=>
		EXT_RD_BLOCKED == !$past(cp_r[3]))
		else $error("block 3 protection wrong");
	a_cp_one_way: assert property (@(posedge CLK) disable iff (!ARST_N) // see R11
		!erase_wr |=> (cp_r & ~$past(cp_r)) == 8'h00)
		else $error("protection bit lifted without erase");
	a_wdt_period: assert property (@(posedge CLK) disable iff (!ARST_N) // see R12
		WDT_TIMEOUT |=> post_cnt_r == 7'h00 && pre_cnt_r == 16'h0000)
		else $error("watchdog did not restart after time-out");

endmodule // config_fuse_bank

/* test/fuse_programmer.sv */
// apb programmer model that writes and reads the fuse bank
`timescale 1ns/1ps
`include "config_fuse_cfg.svh"

module fuse_programmer #(
	parameter bit SMALL_PART = 1'b0
) (
	// clock
	input  wire logic        clk,
	// apb master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [23:0]      paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	logic [3:0] strb;

	initial begin
		strb = 4'hf;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 24'h000000;
		pwdata = 32'h00000000;
		pstrb = 4'hf;
	end

	task automatic xfer(input logic w, input logic [23:0] idx,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		logic [31:0] dv;
		dv = d;
		// small parts lack blocks 2 and 3, so they stay set
		if (SMALL_PART && w && idx == `CFB_IDX_CP)
			dv[3:2] = 2'b11;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx[21:0], 2'b00};
		pwdata <= dv;
		pstrb <= strb;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // fuse_programmer

/* test/testbench.sv */
// self-checking bench for the configuration fuse bank
`timescale 1ns/1ps
`include "config_fuse_cfg.svh"

module testbench;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic                        clk, arst_n;
	logic                        psel, penable, pwrite, pready, pslverr;
	logic [23:0]                 paddr;
	logic [31:0]                 pwdata, prdata;
	logic [3:0]                  pstrb;
	config_fuse_pkg::stack_evt_t stk;
	config_fuse_pkg::pin_drive_t ccp, pc1_drv, pb3_drv;
	logic                        wdt_to, stk_rst, ccp_in, pc1_in, pb3_in;
	logic                        lowv_req, lowv_ok, blk;
	logic [20:0]                 rd_addr;
	int                          errors, cmp_count;

	config_fuse_bank #(.WDT_BASE_CYCLES(16'd8)) DUT (
		.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
		.PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
		.STACK_EVT(stk), .WDT_TIMEOUT(wdt_to), .STACK_RESET(stk_rst),
		.UNIT2_DRV(ccp), .UNIT2_IN(ccp_in), .PC1_IN(pc1_in),
		.PB3_IN(pb3_in), .PC1_DRV(pc1_drv), .PB3_DRV(pb3_drv),
		.LOW_VOLT_REQ(lowv_req), .LOW_VOLT_OK(lowv_ok),
		.EXT_RD_ADDR(rd_addr), .EXT_RD_BLOCKED(blk));

	fuse_programmer #(.SMALL_PART(1'b0)) prog (
		.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task check(input string name, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task wr(input logic [23:0] idx, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		prog.xfer(1'b1, idx, d, q, e);
	endtask

	task rd(input string name, input logic [23:0] idx, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		prog.xfer(1'b0, idx, 32'h0, q, e);
		check(name, q, x);
		check("slverr", {31'h0, e}, 32'h0);
	endtask

	task settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task give_verdict;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset;
		logic [31:0] q;
		logic        e;
		rd("bor", `CFB_IDX_BOR, 32'h0f);
		rd("wdt", `CFB_IDX_WDT, 32'h0f);
		rd("route", `CFB_IDX_ROUTE, 32'h01);
		rd("dps", `CFB_IDX_DPS, 32'h85);
		rd("cp", `CFB_IDX_CP, 32'h0f);
		prog.xfer(1'b0, 24'h300020, 32'h0, q, e);
		check("unmapped_data", q, 32'h0);
		check("unmapped_err", {31'h0, e}, 32'h1);
	endtask

	task t_mask;
		wr(`CFB_IDX_DPS, 32'hffff_ff7a);
		rd("dps_unimpl", `CFB_IDX_DPS, 32'h00);
		wr(`CFB_IDX_DPS, 32'hffff_ffff);
		rd("dps_impl", `CFB_IDX_DPS, 32'h85);
		wr(`CFB_IDX_ROUTE, 32'hffff_fffe);
		rd("route_unimpl", `CFB_IDX_ROUTE, 32'h00);
		wr(`CFB_IDX_ROUTE, 32'hffff_ffff);
		// lane 0 strobe off must leave the byte alone
		prog.strb = 4'he;
		wr(`CFB_IDX_ROUTE, 32'h0);
		prog.strb = 4'hf;
		rd("route_strb", `CFB_IDX_ROUTE, 32'h01);
	endtask

	task t_low_volt;
		lowv_req <= 1'b1;
		settle(4);
		check("lowv_on", {31'h0, lowv_ok}, 32'h1);
		wr(`CFB_IDX_DPS, 32'h81);
		settle(4);
		check("lowv_off", {31'h0, lowv_ok}, 32'h0);
		@(posedge clk);
		lowv_req <= 1'b0;
	endtask

	task t_stack;
		for (int en = 1; en >= 0; en--) begin
			wr(`CFB_IDX_DPS, 32'h84 | 32'(en));
			for (int k = 1; k <= 2; k++) begin
				@(posedge clk);
				stk <= 2'(k);
				@(posedge clk);
				stk <= 2'b00;
				@(negedge clk);
				check("stack_reset", {31'h0, stk_rst}, 32'(en));
			end
		end
	endtask

	task t_route;
		for (int r = 0; r <= 1; r++) begin
			wr(`CFB_IDX_ROUTE, 32'(r));
			pc1_in <= r[0];
			pb3_in <= !r[0];
			// a distinct drive per pin catches swapped out and enable
			ccp <= 2'(r + 1);
			settle(5);
			check("unit2_in", {31'h0, ccp_in}, 32'h1);
			check("pc1_drv", {30'h0, pc1_drv}, r ? 32'h2 : 32'h0);
			check("pb3_drv", {30'h0, pb3_drv}, r ? 32'h0 : 32'h1);
		end
	endtask

	// edges from one timeout pulse to the next
	task period(input int x);
		int n;
		n = 0;
		do begin @(posedge clk); n++; end while (wdt_to !== 1'b1 && n < 3000);
		n = 0;
		do begin @(posedge clk); n++; end while (wdt_to !== 1'b1 && n < 3000);
		check("wdt_period", n, x);
	endtask

	task t_wdt;
		int n;
		wr(`CFB_IDX_WDT, 32'h0);
		n = 0;
		repeat (100) begin @(posedge clk); n += int'(wdt_to === 1'b1); end
		check("wdt_stopped", n, 0);
		wr(`CFB_IDX_WCTL, 32'h1);
		period(8);
		wr(`CFB_IDX_WCTL, 32'h0);
		// ascending, so a running count never overshoots
		for (int s = 0; s < 8; s++) begin
			wr(`CFB_IDX_WDT, 32'(s * 2 + 1));
			period(8 << s);
		end
		// the stack flag stands from t_stack, the time-out flag from the periods above
		rd("wstat", `CFB_IDX_WSTAT, 32'h7);
		wr(`CFB_IDX_WSTAT, 32'h6);
		rd("wstat_clr", `CFB_IDX_WSTAT, 32'h1);
		// a kick restarts the whole count, so a full period follows
		wr(`CFB_IDX_WCTL, 32'h2);
		n = 0;
		do begin @(posedge clk); n++; end while (wdt_to !== 1'b1 && n < 3000);
		check("wdt_kick", n, 8 << 7);
	endtask

	task t_protect;
		for (int b = 0; b < 4; b++) begin
			wr(`CFB_IDX_CP, 32'h0f & ~(32'h1 << b));
			rd("cp_and", `CFB_IDX_CP, 32'h0f & ~((32'h2 << b) - 1));
			for (int j = 0; j < 4; j++) begin
				@(posedge clk);
				rd_addr <= 21'(j * 32'h2000 + 32'h300);
				settle(2);
				check("blocked", {31'h0, blk}, 32'(j <= b));
			end
		end
		@(posedge clk);
		rd_addr <= 21'h000100;
		settle(2);
		check("boot_open", {31'h0, blk}, 32'h0);
		wr(`CFB_IDX_CP, 32'h0f);
		rd("cp_sticky", `CFB_IDX_CP, 32'h00);
		wr(`CFB_IDX_ERASE, 32'h1);
		rd("cp_erased", `CFB_IDX_CP, 32'h0f);
	endtask

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		give_verdict;
	end

	initial begin
		arst_n = 1'b0;
		stk = 2'b00;
		ccp = 2'b11;
		pc1_in = 1'b0;
		pb3_in = 1'b0;
		lowv_req = 1'b0;
		rd_addr = 21'h0;
		errors = 0;
		cmp_count = 0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		t_reset;
		t_mask;
		t_low_volt;
		t_stack;
		t_route;
		t_wdt;
		t_protect;
		give_verdict;
	end
endmodule // testbench
